// File: shared/tsfe_defines.svh
// Constants for the special trace record encoder
`ifndef TSFE_DEFINES_SVH
`define TSFE_DEFINES_SVH
`define TSFE_REC_W 48
`define TSFE_LEN_W 6
`define TSFE_TID_W 8
`define TSFE_TIDW_W 3
`define TSFE_PIECE_W 56
`define TSFE_MAX_PIPES 4
`define TSFE_OUT_W 256
`define TSFE_OLEN_W 9
`define TSFE_BKPT_N 16
`define TSFE_CNT_W 8
`define TSFE_OVFCNT_W 16
`define TSFE_OVF_REC 4'h4
`define TSFE_OVF_LEN 9'h004
`define TSFE_STALL_REC 1'b1
`define TSFE_CTL_PFX 4'hC
`define TSFE_CTL_LEN 9'h010
`define TSFE_CODE_START 4'h0
`define TSFE_CODE_END 4'h4
`define TSFE_CODE_INFO 4'hC
`define TSFE_CODE_NOTRACE 4'h3
`define TSFE_CODE_BSTALL 4'h5
`define TSFE_CODE_BKPT 4'h9
`define TSFE_CODE_TID 4'hE
`define TSFE_TTS_COARSE 2'h1
`define TSFE_TTS_FINE 2'h2
`define TSFE_ADDR_W 8
`define TSFE_ADDR_CTRL 8'h00
`define TSFE_ADDR_STATUS 8'h04
`define TSFE_ADDR_OVFCNT 8'h08
`define TSFE_CTRL_W 7
`define TSFE_CTRL_RST 7'h00
`endif

// File: shared/tsfe_pkg.sv
// Types for the special trace record encoder
`include "tsfe_defines.svh"
package tsfe_pkg;
   typedef struct packed {
      logic done;
      logic ovf;
      logic [`TSFE_TID_W-1:0] tid;
      logic [`TSFE_LEN_W-1:0] len;
      logic [`TSFE_REC_W-1:0] bits;
   } tsfe_pipe_t;
   typedef struct packed {
      logic start;
      logic stop;
      logic info_pt;
      logic [7:0] cause;
      logic [`TSFE_BKPT_N-1:0] bkpt_hit;
      logic bkpt_data;
      logic bkpt_on;
      logic bkpt_cm;
   } tsfe_trig_t;
   typedef struct packed {
      logic [`TSFE_TIDW_W-1:0] thread_id_width;
      logic [1:0] thread_trace_select;
      logic cycle_accurate;
      logic enable;
   } tsfe_ctrl_t;
   typedef struct packed {
      logic valid;
      logic [`TSFE_OLEN_W-1:0] len;
      logic [`TSFE_OUT_W-1:0] data;
   } tsfe_out_t;
   typedef struct packed {
      logic [`TSFE_CNT_W-1:0] cnt;
      logic pend;
      logic [`TSFE_CNT_W-1:0] info;
   } tsfe_cnt_t;
   typedef struct packed {
      tsfe_ctrl_t ctrl;
      tsfe_out_t out;
      logic resync;
      logic trace_on;
      logic tid_seen;
      logic [`TSFE_TID_W-1:0] tid_last;
      tsfe_cnt_t nt;
      tsfe_cnt_t bs;
      logic [`TSFE_OVFCNT_W-1:0] ovf_cnt;
      logic wr_pend;
      logic [`TSFE_ADDR_W-1:0] wr_addr;
      logic [31:0] rdata;
   } tsfe_state_t;
endpackage

// File: hw/tsfe_encoder.sv
// Special trace record encoder with AHB-Lite register slave
`timescale 1ns/1ps
`include "tsfe_defines.svh"
module tsfe_encoder import tsfe_pkg::*; #(
   parameter int NPIPE = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire tsfe_pipe_t [NPIPE-1:0] pipe_in,
   input wire tsfe_trig_t trig_in,
   input wire logic core_no_trace,
   input wire logic back_stall,
   output tsfe_out_t rec_out,
   output logic pc_resync_req,
   output logic trace_active
);
   tsfe_state_t s;
   tsfe_state_t n;
   logic [`TSFE_PIECE_W-1:0] pp_data [NPIPE];
   logic [`TSFE_OLEN_W-1:0] pp_len [NPIPE];
   logic [`TSFE_TID_W-1:0] tid_mask;
   logic fine;
   logic coarse;
   logic stall_on;

   if (NPIPE < 1 || NPIPE > `TSFE_MAX_PIPES) begin : g_chk
      $error("tsfe_encoder: NPIPE out of range");
   end

   // Counter closes a run when the condition drops or 256 is reached
   function automatic tsfe_cnt_t cnt_step(tsfe_cnt_t c, logic on, logic take);
      tsfe_cnt_t r;
      r = c;
      if (take) begin
         r.pend = 1'b0;
      end
      if (on) begin
         r.cnt = c.cnt + `TSFE_CNT_W'(1);
         if (r.cnt == '0) begin
            r.pend = 1'b1;
            r.info = '0;
         end
      end else if (c.cnt != '0) begin
         r.pend = 1'b1;
         r.info = c.cnt;
         r.cnt = '0;
      end
      return r;
   endfunction

   assign fine = (s.ctrl.thread_trace_select == `TSFE_TTS_FINE);
   assign coarse = (s.ctrl.thread_trace_select == `TSFE_TTS_COARSE);
   assign stall_on = s.ctrl.cycle_accurate;
   assign tid_mask = `TSFE_TID_W'((9'h001 << s.ctrl.thread_id_width) - 9'h001);

   for (genvar g = 0; g < NPIPE; g++) begin : g_pipe
      logic [`TSFE_PIECE_W-1:0] body;
      logic [`TSFE_PIECE_W-1:0] pfx;
      assign body = `TSFE_PIECE_W'(pipe_in[g].bits);
      // Id sits above the record bits, stall records get none
      assign pfx = fine ? (`TSFE_PIECE_W'(pipe_in[g].tid & tid_mask) << pipe_in[g].len)
                        : '0;
      assign pp_data[g] = pipe_in[g].done ? (body | pfx)
                        : (stall_on ? `TSFE_PIECE_W'(`TSFE_STALL_REC) : '0);
      assign pp_len[g] = pipe_in[g].done
                       ? (`TSFE_OLEN_W'(pipe_in[g].len)
                          + (fine ? `TSFE_OLEN_W'(s.ctrl.thread_id_width) : '0))
                       : (stall_on ? `TSFE_OLEN_W'(1) : '0);
   end

   logic addr_ph;
   logic en;
   logic any_ovf;
   logic bk_any;
   logic [3:0] bk_num;
   logic turn_on;
   logic turn_off;
   logic on_now;
   logic tid_chg;
   logic ctl_sel;
   logic [3:0] ctl_code;
   logic [7:0] ctl_info;
   logic take_nt;
   logic take_bs;
   logic [`TSFE_OUT_W-1:0] o_data;
   logic [`TSFE_OLEN_W-1:0] o_len;
   logic [`TSFE_CTL_LEN*1-1:0] ctl_rec;
   logic [`TSFE_CTL_LEN*1-1:0] tid_rec;

   assign addr_ph = hsel & htrans[1] & hready;

   always_comb begin
      n = s;
      n.resync = 1'b0;
      // Write data is taken in the data phase
      if (s.wr_pend && s.wr_addr == `TSFE_ADDR_CTRL) begin
         n.ctrl = tsfe_ctrl_t'(hwdata[`TSFE_CTRL_W-1:0]);
      end
      n.wr_pend = 1'b0;
      if (addr_ph) begin
         n.wr_pend = hwrite;
         n.wr_addr = haddr[`TSFE_ADDR_W-1:0];
      end

      en = s.ctrl.enable;
      any_ovf = 1'b0;
      for (int i = 0; i < NPIPE; i++) begin
         any_ovf = any_ovf | pipe_in[i].ovf;
      end
      any_ovf = any_ovf & en;
      bk_any = |trig_in.bkpt_hit;
      bk_num = '0;
      // Lowest numbered breakpoint wins
      for (int i = `TSFE_BKPT_N - 1; i >= 0; i--) begin
         if (trig_in.bkpt_hit[i]) begin
            bk_num = 4'(i);
         end
      end
      turn_on = trig_in.start | (bk_any & trig_in.bkpt_on);
      turn_off = trig_in.stop | (bk_any & ~trig_in.bkpt_on);
      on_now = en & (s.trace_on | turn_on);
      tid_chg = coarse & on_now & ~any_ovf & pipe_in[0].done
              & (~s.tid_seen | (pipe_in[0].tid != s.tid_last));

      // One event control record per cycle besides the thread id record; lower priority triggers are dropped, pending counts wait
      ctl_sel = ~any_ovf & on_now;
      ctl_code = `TSFE_CODE_START;
      ctl_info = trig_in.cause;
      take_nt = 1'b0;
      take_bs = 1'b0;
      if (trig_in.start) begin
         ctl_code = `TSFE_CODE_START;
      end else if (trig_in.stop) begin
         ctl_code = `TSFE_CODE_END;
      end else if (trig_in.info_pt) begin
         ctl_code = `TSFE_CODE_INFO;
      end else if (bk_any) begin
         ctl_code = `TSFE_CODE_BKPT;
         ctl_info = {1'b0, trig_in.bkpt_cm, bk_num, trig_in.bkpt_on, trig_in.bkpt_data};
      end else if (s.nt.pend) begin
         ctl_code = `TSFE_CODE_NOTRACE;
         ctl_info = s.nt.info;
         take_nt = ctl_sel;
      end else if (s.bs.pend && s.ctrl.cycle_accurate) begin
         ctl_code = `TSFE_CODE_BSTALL;
         ctl_info = s.bs.info;
         take_bs = ctl_sel;
      end else begin
         ctl_sel = 1'b0;
      end
      ctl_rec = {ctl_info, ctl_code, `TSFE_CTL_PFX};
      tid_rec = {pipe_in[0].tid & tid_mask, `TSFE_CODE_TID, `TSFE_CTL_PFX};

      n.nt = cnt_step(s.nt, en & s.trace_on & core_no_trace & ~back_stall, take_nt);
      n.bs = cnt_step(s.bs, en & s.trace_on & back_stall & s.ctrl.cycle_accurate, take_bs);
      if (!s.ctrl.cycle_accurate) begin
         n.bs.pend = 1'b0;
      end

      o_data = '0;
      o_len = '0;
      if (any_ovf) begin
         o_data = `TSFE_OUT_W'(`TSFE_OVF_REC);
         o_len = `TSFE_OVF_LEN;
         n.resync = 1'b1;
         n.ovf_cnt = s.ovf_cnt + `TSFE_OVFCNT_W'(1);
      end else if (on_now) begin
         if (tid_chg) begin
            o_data = `TSFE_OUT_W'(tid_rec);
            o_len = `TSFE_CTL_LEN;
            n.tid_last = pipe_in[0].tid;
            n.tid_seen = 1'b1;
         end
         for (int i = 0; i < NPIPE; i++) begin
            o_data = o_data | (`TSFE_OUT_W'(pp_data[i]) << o_len);
            o_len = o_len + pp_len[i];
         end
         if (ctl_sel) begin
            // Trails the pipe records, so a turn-off record is the last one
            o_data = o_data | (`TSFE_OUT_W'(ctl_rec) << o_len);
            o_len = o_len + `TSFE_CTL_LEN;
         end
      end
      n.out.data = o_data;
      n.out.len = o_len;
      n.out.valid = (o_len != '0);

      if (!en) begin
         n.trace_on = 1'b0;
         n.tid_seen = 1'b0;
      end else if (!any_ovf) begin
         n.trace_on = turn_on ? 1'b1 : (turn_off ? 1'b0 : s.trace_on);
      end

      // Read data is latched in the address phase, using the updated values
      if (addr_ph && !hwrite) begin
         unique case (haddr[`TSFE_ADDR_W-1:0])
            `TSFE_ADDR_CTRL: n.rdata = 32'(n.ctrl);
            `TSFE_ADDR_STATUS: n.rdata = 32'({n.tid_last, n.bs.pend, n.nt.pend, n.trace_on});
            `TSFE_ADDR_OVFCNT: n.rdata = 32'(n.ovf_cnt);
            default: n.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.ctrl <= tsfe_ctrl_t'(`TSFE_CTRL_RST);
      end else begin
         s <= n;
      end
   end

   assign hrdata = s.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rec_out = s.out;
   assign pc_resync_req = s.resync;
   assign trace_active = s.trace_on;
endmodule

// File: test/tsfe_assertions.sv
// Port-level checks of the special trace record encoder
`timescale 1ns/1ps
module tsfe_checker import tsfe_pkg::*; #(
   parameter int NPIPE = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire tsfe_pipe_t [NPIPE-1:0] pipe_in,
   input wire tsfe_trig_t trig_in,
   input wire tsfe_out_t rec_out,
   input wire logic pc_resync_req,
   input wire logic trace_active
);
   logic ovf;
   logic done;
   logic ctl;
   logic one;
   logic [3:0] low;
   logic [15:0] w;
   always_comb begin
      ovf = 1'b0;
      done = 1'b0;
      low = 4'h0;
      for (int i = 0; i < NPIPE; i++) begin
         ovf |= pipe_in[i].ovf;
         done |= pipe_in[i].done;
      end
      for (int i = 15; i >= 0; i--) begin
         if (trig_in.bkpt_hit[i]) begin
            low = 4'(i);
         end
      end
   end
   // Event control record sits in the top 16 bits; a thread id record goes below the pipe records
   assign w = rec_out.data[rec_out.len - 9'd1 -: 16];
   assign ctl = rec_out.valid && rec_out.len >= 9'h010;
   assign one = rec_out.valid && rec_out.len == 9'h010;
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_ovf_alone: assert property (ovf |=> !rec_out.valid || rec_out.len == 9'h004
      && rec_out.data[3:0] == 4'h4) else $error("overflow output not alone");
   // Resync request is registered together with the overflow record
   a_resync_after: assert property (ovf ##1 rec_out.valid |-> pc_resync_req)
      else $error("no resync after overflow");
   a_resync_cause: assert property (pc_resync_req |-> $past(ovf))
      else $error("resync without overflow");
   a_start_rec: assert property ($past(trig_in.start && !ovf) && ctl
      |-> w == {$past(trig_in.cause), 8'h0C}) else $error("bad start record");
   a_end_rec: assert property ($past(trig_in.stop && !trig_in.start && !ovf) && ctl
      |-> w == {$past(trig_in.cause), 8'h4C}) else $error("bad end record");
   a_info_rec: assert property ($past(trig_in.info_pt && !trig_in.start && !trig_in.stop
      && !ovf) && ctl |-> w == {$past(trig_in.cause), 8'hCC}) else $error("bad info record");
   a_bkpt_rec: assert property ($past(trig_in.bkpt_hit != 16'h0000 && !ovf) && ctl
      && $past(!trig_in.start && !trig_in.stop && !trig_in.info_pt) |-> w == {1'b0,
      $past(trig_in.bkpt_cm), $past(low), $past(trig_in.bkpt_on), $past(trig_in.bkpt_data),
      8'h9C}) else $error("bad breakpoint record");
   a_no_reserved: assert property (one && $past(!done) && w[3:0] == 4'hC
      |-> !(w[7:4] inside {4'h8, 4'hD, 4'h2, 4'h6, 4'hA})) else $error("reserved code");
   a_off_quiet: assert property (rec_out.valid |-> $past(trace_active || trig_in.start
      || ovf || trig_in.bkpt_on)) else $error("record while trace off");
   c_ovf: cover property (ovf ##1 rec_out.valid);
   c_bkpt: cover property (ctl && w[7:0] == 8'h9C);
   c_stop: cover property ($fell(trace_active));
endmodule

// File: test/tsfe_trace_mem.sv
// Trace memory model keeping the newest lone control record
`timescale 1ns/1ps
module tsfe_trace_mem import tsfe_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire tsfe_out_t rec_out,
   output logic [15:0] last_ctl,
   output logic [15:0] n_rec
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_ctl <= 16'h0000;
         n_rec <= 16'h0000;
      end else if (rec_out.valid) begin
         n_rec <= n_rec + 16'h0001;
         if (rec_out.len == 9'h010) begin
            last_ctl <= rec_out.data[15:0];
         end
      end
   end
endmodule

// File: test/testbench.sv
// Self-checking bench for the special trace record encoder
`timescale 1ns/1ps
module testbench import tsfe_pkg::*;;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   tsfe_pipe_t [1:0] pipe_in;
   tsfe_trig_t trig_in;
   tsfe_out_t rec_out;
   logic core_no_trace, back_stall, pc_resync_req, trace_active;
   logic [15:0] last_ctl, n_rec, n0;
   int err_total = 0;
   int cmp_count = 0;
   int tick = 0;
   assign hready = hreadyout;
   tsfe_encoder #(.NPIPE(2)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pipe_in(pipe_in), .trig_in(trig_in), .core_no_trace(core_no_trace),
      .back_stall(back_stall), .rec_out(rec_out), .pc_resync_req(pc_resync_req),
      .trace_active(trace_active));
   tsfe_trace_mem i_mem (.hclk(hclk), .hresetn(hresetn), .rec_out(rec_out),
      .last_ctl(last_ctl), .n_rec(n_rec));
   task automatic report_and_stop;
      if (err_total == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   // Address phase held until hready, then data phase until hready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic load(input int i, input logic [5:0] n, input logic [47:0] b,
      input logic [7:0] t);
      pipe_in[i].done <= 1'b1;
      pipe_in[i].len <= n;
      pipe_in[i].bits <= b;
      pipe_in[i].tid <= t;
   endtask
   // Output of the loaded cycle is readable when this returns
   task automatic fire;
      @(posedge hclk);
      pipe_in <= '0;
      trig_in <= '0;
      @(posedge hclk);
   endtask
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      tick++;
      if (tick == 3000) begin
         err_total++;
         report_and_stop;
      end
   end
   initial begin
      {hsel, hwrite, haddr, hwdata, htrans, core_no_trace, back_stall} = '0;
      hsize = 3'h2;
      pipe_in = '0;
      trig_in = '0;
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl_rst", r, 32'h0);
      bus(1'b1, 32'h10, 32'hFF);
      bus(1'b0, 32'h10, 32'h0);
      chk("unmapped", r, 32'h0);
      bus(1'b1, 32'h0, 32'h1);
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl", r, 32'h1);
      trig_in.start <= 1'b1;
      trig_in.cause <= 8'h5A;
      fire;
      chk("start", {rec_out.len, rec_out.data[15:0], trace_active}, {9'd16, 16'h5A0C, 1'b1});
      load(0, 6'd5, 48'h15, 8'h0);
      load(1, 6'd3, 48'h2, 8'h0);
      trig_in.info_pt <= 1'b1;
      trig_in.cause <= 8'h33;
      fire;
      chk("order", {rec_out.len, rec_out.data[23:0]}, {9'd24, 16'h33CC, 3'h2, 5'h15});
      load(0, 6'd5, 48'h15, 8'h0);
      pipe_in[1].ovf <= 1'b1;
      trig_in.stop <= 1'b1;
      fire;
      chk("ovf", {rec_out.len, rec_out.data[3:0]}, {9'd4, 4'h4});
      // Resync request stands beside the overflow record for one cycle only
      chk("resync", {pc_resync_req, trace_active}, 2'h3);
      @(posedge hclk);
      chk("resync_end", pc_resync_req, 1'b0);
      bus(1'b0, 32'h8, 32'h0);
      chk("ovfcnt", {hreadyout, hresp, r}, {1'b1, 1'b0, 32'h1});
      bus(1'b1, 32'h0, 32'h3);
      fire;
      chk("stall", {rec_out.len, rec_out.data[1:0]}, {9'd2, 2'h3});
      back_stall <= 1'b1;
      repeat (2) @(posedge hclk);
      back_stall <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("bstall", {rec_out.len, rec_out.data[17:0]}, {9'h012, 16'h025C, 2'h3});
      bus(1'b1, 32'h0, 32'h1);
      core_no_trace <= 1'b1;
      repeat (3) @(posedge hclk);
      core_no_trace <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("notrace", last_ctl, 16'h033C);
      // Not cycle accurate: a back-stall run must leave no record
      back_stall <= 1'b1;
      repeat (2) @(posedge hclk);
      back_stall <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("bs_off", last_ctl, 16'h033C);
      trig_in.stop <= 1'b1;
      trig_in.cause <= 8'h77;
      fire;
      chk("stop", {rec_out.data[15:0], trace_active}, {16'h774C, 1'b0});
      @(posedge hclk);
      n0 = n_rec;
      load(0, 6'd5, 48'h15, 8'h0);
      fire;
      @(posedge hclk);
      chk("quiet", n_rec, n0);
      trig_in.bkpt_hit <= 16'h000C;
      trig_in.bkpt_data <= 1'b1;
      trig_in.bkpt_on <= 1'b1;
      fire;
      chk("bkpt", rec_out.data[15:0], 16'h0B9C);
      bus(1'b1, 32'h0, 32'h49);
      load(0, 6'd3, 48'h5, 8'hFA);
      fire;
      chk("fine", {rec_out.len, rec_out.data[6:0]}, {9'd7, 4'hA, 3'h5});
      bus(1'b1, 32'h0, 32'h45);
      load(0, 6'd3, 48'h5, 8'h03);
      fire;
      chk("coarse", {rec_out.len, rec_out.data[18:0]}, {9'd19, 3'h5, 16'h03EC});
      bus(1'b0, 32'h4, 32'h0);
      chk("status", r, 32'h19);
      report_and_stop;
   end
endmodule
bind tsfe_encoder tsfe_checker #(.NPIPE(NPIPE)) i_chk (.hclk(hclk), .hresetn(hresetn),
   .pipe_in(pipe_in), .trig_in(trig_in), .rec_out(rec_out), .pc_resync_req(pc_resync_req),
   .trace_active(trace_active));
